// ==== common/dr_evt_if.sv ====
// Signals between the counter core and the event input conditioner
interface dr_evt_if;
   logic pin;
   logic ref_fall;
   logic polarity;
   logic filt_en;
   logic evt_tick;

   modport cond (input pin, input ref_fall, input polarity, input filt_en, output evt_tick);
   modport core (output pin, output ref_fall, output polarity, output filt_en, input evt_tick);
endinterface : dr_evt_if

// ==== common/dr_pkg.sv ====
// Constants, register map and types shared by the dual reload down counter
package dr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register bus
   localparam int unsigned APB_AW     = 8;
   localparam int unsigned APB_DW     = 32;
   localparam logic [7:0]  OFS_CTRL   = 8'h00;
   localparam logic [7:0]  OFS_CLKSEL = 8'h04;
   localparam logic [7:0]  OFS_RLD0   = 8'h08;
   localparam logic [7:0]  OFS_RLD1   = 8'h0C;
   localparam logic [7:0]  OFS_PRESET = 8'h10;
   localparam logic [7:0]  OFS_CNT0   = 8'h14;
   localparam logic [7:0]  OFS_CNT1   = 8'h18;
   localparam logic [7:0]  OFS_FLAG   = 8'h1C;
   localparam logic [7:0]  OFS_IRQEN  = 8'h20;

   ////////////////////////////////////////////////////////////////////////////
   // Control register fields
   localparam int unsigned CTRL_W     = 7;
   localparam int unsigned CB_CHAIN   = 0;
   localparam int unsigned CB_EVT     = 1;
   localparam int unsigned CB_POL     = 2;
   localparam int unsigned CB_FILT    = 3;
   localparam int unsigned CB_PULSE_OUT_CHANNEL_SELECT   = 4;
   localparam int unsigned CB_RUN0    = 5;
   localparam int unsigned CB_RUN1    = 6;
   localparam logic [6:0]  CTRL_RST   = 7'h00;

   // Clock select register fields
   localparam int unsigned CLK_W      = 7;
   localparam int unsigned KB_PS0     = 0;
   localparam int unsigned KB_SRC0    = 2;
   localparam int unsigned KB_PS1     = 4;
   localparam int unsigned KB_SRC1    = 6;
   localparam logic [6:0]  CLK_RST    = 7'h00;

   localparam logic [7:0]  RLD_RST    = 8'h00;
   localparam logic [7:0]  CNT_RST    = 8'h00;
   localparam logic [7:0]  CNT_MAX    = 8'hFF;

   // Prescaler ratio codes
   localparam logic [1:0]  PS_DIV1    = 2'h0;
   localparam logic [1:0]  PS_DIV4    = 2'h1;
   localparam logic [1:0]  PS_DIV32   = 2'h2;
   localparam logic [1:0]  PS_DIV256  = 2'h3;

   ////////////////////////////////////////////////////////////////////////////
   // Pin sampling and noise rejector reference
   localparam int unsigned NSYNC      = 3;
   localparam int unsigned LF_HZ      = 32768;
   localparam int unsigned REF_HZ     = 2048;
   localparam int unsigned REF_DIV    = LF_HZ / REF_HZ;
   localparam int unsigned REF_CW     = $clog2(REF_DIV);
   localparam logic [REF_CW-1:0] REF_LAST = REF_CW'(REF_DIV - 1);
   localparam logic [1:0]  FILT_EDGES = 2'h2;

   typedef enum logic [0:0] {FS_STABLE, FS_PENDING} dr_filt_e;

endpackage : dr_pkg

// ==== rtl/dr_counter_top.sv ====
// Dual 8-bit reload down counter with chaining, event input and APB registers
//
// Notes on behaviour
// - Two 8-bit down counters, each with reload
// - Chain bit joins both into one 16-bit counter
// - Preset strobe copies reload value into counter
// - Run bit gates counting, never changes count
// - Current count readable at any time
// - Low read freezes high part until read
// - Underflow reloads and counting simply continues
// - Underflow drives interrupt and pulse output pin
// - Channel 1 underflow clocks the serial interface
// - Mode bit zero: channel 0 counts prescaler ticks
// - Unchained channel 1 counts prescaler ticks only; chained, it counts channel 0 borrows
// - Mode bit one: channel 0 counts pin edges
// - Event mode ignores channel 0 prescaler settings
// - Polarity bit: zero falling, one rising edge
// - Filter bit inserts noise rejector on event pin
// - Filtered change passes at second reference falling edge
// - Pulses of 0.48 ms or less are discarded
// - Prescaler divides by 1, 4, 32, 256
// - Source bit: low or high frequency oscillator
// - Flag always sets; mask gates request only
// - Pulse output toggles on selected channel underflow
module dr_counter_top (
   input  wire logic                        CLK_IN,
   input  wire logic                        RST_IN,
   input  wire logic                        PSEL_IN,
   input  wire logic                        PENABLE_IN,
   input  wire logic                        PWRITE_IN,
   input  wire logic [dr_pkg::APB_AW-1:0]   PADDR_IN,
   input  wire logic [dr_pkg::APB_DW-1:0]   PWDATA_IN,
   output logic      [dr_pkg::APB_DW-1:0]   PRDATA_OUT,
   output logic                             PREADY_OUT,
   output logic                             PSLVERR_OUT,
   input  wire logic                        LOW_FREQ_OSC_IN,
   input  wire logic                        HIGH_FREQ_OSC_IN,
   input  wire logic                        EVENT_INPUT_PIN_IN,
   output logic                             PULSE_OUTPUT_OUT,
   output logic                             SIO_CLK_OUT,
   output logic [1:0]                       UNDERFLOW_OUT,
   output logic [1:0]                       IRQ_OUT
);
   import dr_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Decoding helpers
   function automatic logic ratio_hit(input logic [7:0] c, input logic [1:0] sel);
      case (sel)
         PS_DIV1:  ratio_hit = 1'b1;
         PS_DIV4:  ratio_hit = &c[1:0];
         PS_DIV32: ratio_hit = &c[4:0];
         default:  ratio_hit = &c[7:0];
      endcase
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      case (a)
         OFS_CTRL, OFS_CLKSEL, OFS_RLD0, OFS_RLD1, OFS_PRESET,
         OFS_CNT0, OFS_CNT1, OFS_FLAG, OFS_IRQEN: is_mapped = 1'b1;
         default:                                 is_mapped = 1'b0;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // APB handshake: one wait state so read data leave a flip-flop
   logic [CTRL_W-1:0] ctrl_r,    ctrl_nxt;
   logic [CLK_W-1:0]  clksel_r,  clksel_nxt;
   logic [7:0]        rld_r [2];
   logic [7:0]        rld_nxt [2];
   logic [1:0]        irqen_r,   irqen_nxt;
   logic [7:0]        hold_r,    hold_nxt;
   logic              hold_v_r,  hold_v_nxt;
   logic [31:0]       prdata_r,  prdata_nxt;
   logic              pready_r,  pready_nxt;
   logic              pslverr_r, pslverr_nxt;
   logic [7:0]        cnt_r [2];
   logic [1:0]        flag_r;

   logic acc, done, wr, rd;
   logic [1:0] preset, flag_clr;

   assign acc  = PSEL_IN & PENABLE_IN;
   assign done = acc & pready_r;
   assign wr   = done & PWRITE_IN & is_mapped(PADDR_IN);
   assign rd   = done & ~PWRITE_IN;

   always_comb begin
      ctrl_nxt    = ctrl_r;
      clksel_nxt  = clksel_r;
      rld_nxt[0]  = rld_r[0];
      rld_nxt[1]  = rld_r[1];
      irqen_nxt   = irqen_r;
      hold_nxt    = hold_r;
      hold_v_nxt  = hold_v_r;
      preset      = 2'h0;
      flag_clr    = 2'h0;
      pready_nxt  = acc & ~pready_r;
      prdata_nxt  = 32'h0;
      pslverr_nxt = 1'b0;
      if (acc && !pready_r) begin
         pslverr_nxt = ~is_mapped(PADDR_IN);
         if (!PWRITE_IN) begin
            case (PADDR_IN)
               OFS_CTRL:   prdata_nxt = {25'h0, ctrl_r};
               OFS_CLKSEL: prdata_nxt = {25'h0, clksel_r};
               OFS_RLD0:   prdata_nxt = {24'h0, rld_r[0]};
               OFS_RLD1:   prdata_nxt = {24'h0, rld_r[1]};
               OFS_CNT0:   prdata_nxt = {24'h0, cnt_r[0]};
               OFS_CNT1:   prdata_nxt = {24'h0, hold_v_r ? hold_r : cnt_r[1]};
               OFS_FLAG:   prdata_nxt = {30'h0, flag_r};
               OFS_IRQEN:  prdata_nxt = {30'h0, irqen_r};
               default:    prdata_nxt = 32'h0;
            endcase
         end
      end
      if (wr) begin
         case (PADDR_IN)
            OFS_CTRL:   ctrl_nxt   = PWDATA_IN[CTRL_W-1:0];
            OFS_CLKSEL: clksel_nxt = PWDATA_IN[CLK_W-1:0];
            OFS_RLD0:   rld_nxt[0] = PWDATA_IN[7:0];
            OFS_RLD1:   rld_nxt[1] = PWDATA_IN[7:0];
            OFS_PRESET: preset     = PWDATA_IN[1:0];
            OFS_FLAG:   flag_clr   = PWDATA_IN[1:0];
            OFS_IRQEN:  irqen_nxt  = PWDATA_IN[1:0];
            default:    preset     = 2'h0;
         endcase
      end
      // Freeze taken at the edge that samples the low byte, so no borrow slips in between
      if (acc && !pready_r && !PWRITE_IN && PADDR_IN == OFS_CNT0) begin
         hold_nxt   = cnt_r[1];
         hold_v_nxt = 1'b1;
      end else if (rd && PADDR_IN == OFS_CNT1) begin
         hold_v_nxt = 1'b0;
      end
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         ctrl_r    <= CTRL_RST;
         clksel_r  <= CLK_RST;
         rld_r[0]  <= RLD_RST;
         rld_r[1]  <= RLD_RST;
         irqen_r   <= 2'h0;
         hold_r    <= CNT_RST;
         hold_v_r  <= 1'b0;
         prdata_r  <= 32'h0;
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
      end else begin
         ctrl_r    <= ctrl_nxt;
         clksel_r  <= clksel_nxt;
         rld_r[0]  <= rld_nxt[0];
         rld_r[1]  <= rld_nxt[1];
         irqen_r   <= irqen_nxt;
         hold_r    <= hold_nxt;
         hold_v_r  <= hold_v_nxt;
         prdata_r  <= prdata_nxt;
         pready_r  <= pready_nxt;
         pslverr_r <= pslverr_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Oscillator pins: three-stage sampling, a tick per agreed rising edge
   logic [1:0] osc_pin, osc_tick;
   assign osc_pin = {HIGH_FREQ_OSC_IN, LOW_FREQ_OSC_IN};

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_osc
         logic [NSYNC-1:0] s_r, s_nxt;
         logic             l_r, l_nxt;
         always_comb begin
            s_nxt = {s_r[NSYNC-2:0], osc_pin[gi]};
            l_nxt = (s_r[1] == s_r[2]) ? s_r[2] : l_r;
         end
         always_ff @(posedge CLK_IN) begin
            if (RST_IN) begin
               s_r <= '0;
               l_r <= 1'b0;
            end else begin
               s_r <= s_nxt;
               l_r <= l_nxt;
            end
         end
         assign osc_tick[gi] = l_nxt & ~l_r;
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Reference for the noise rejector, divided from the low frequency source
   logic [REF_CW-1:0] ref_cnt_r, ref_cnt_nxt;
   logic              ref_fall_r, ref_fall_nxt;

   always_comb begin
      ref_cnt_nxt  = osc_tick[0] ? ref_cnt_r + REF_CW'(1) : ref_cnt_r;
      // Top bit of the divider falls as it wraps
      ref_fall_nxt = osc_tick[0] && (ref_cnt_r == REF_LAST);
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         ref_cnt_r  <= '0;
         ref_fall_r <= 1'b0;
      end else begin
         ref_cnt_r  <= ref_cnt_nxt;
         ref_fall_r <= ref_fall_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Event input conditioner
   dr_evt_if ev ();
   assign ev.pin      = EVENT_INPUT_PIN_IN;
   assign ev.ref_fall = ref_fall_r;
   assign ev.polarity = ctrl_r[CB_POL];
   assign ev.filt_en  = ctrl_r[CB_FILT];

   dr_evt_cond u_evt (
      .clk_in (CLK_IN),
      .rst_in (RST_IN),
      .ev     (ev.cond)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Prescalers; in chained mode channel 0's run bit starts both halves
   logic       chain, evt_mode;
   logic [1:0] run, ps_tick;
   logic [1:0] ps_sel [2];
   logic [1:0] src_sel;

   assign chain     = ctrl_r[CB_CHAIN];
   assign evt_mode  = ctrl_r[CB_EVT];
   assign run[0]    = ctrl_r[CB_RUN0];
   assign run[1]    = chain ? ctrl_r[CB_RUN0] : ctrl_r[CB_RUN1];
   assign ps_sel[0] = clksel_r[KB_PS0 +: 2];
   assign ps_sel[1] = clksel_r[KB_PS1 +: 2];
   assign src_sel   = {clksel_r[KB_SRC1], clksel_r[KB_SRC0]};

   generate
      for (gi = 0; gi < 2; gi++) begin : g_ps
         logic [7:0] p_r, p_nxt;
         logic       src;
         assign src = src_sel[gi] ? osc_tick[1] : osc_tick[0];
         always_comb begin
            p_nxt = (run[gi] && src) ? p_r + 8'h01 : p_r;
         end
         always_ff @(posedge CLK_IN) begin
            if (RST_IN) begin
               p_r <= 8'h00;
            end else begin
               p_r <= p_nxt;
            end
         end
         assign ps_tick[gi] = run[gi] & src & ratio_hit(p_r, ps_sel[gi]);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Down counters, underflow and reload
   logic [7:0] cnt_nxt [2];
   logic [1:0] uf_now, tick;
   logic [1:0] uf_r, flag_nxt, irq_r, irq_nxt;
   logic       pulse_r, pulse_nxt, sio_r, sio_nxt;

   // Run is gated into the tick itself, so stopping never touches the count
   assign tick[0] = run[0] & (evt_mode ? ev.evt_tick : ps_tick[0]);
   assign tick[1] = ~chain & run[1] & ps_tick[1];

   always_comb begin
      cnt_nxt[0] = cnt_r[0];
      cnt_nxt[1] = cnt_r[1];
      uf_now     = 2'h0;
      if (chain) begin
         if (tick[0]) begin
            if (cnt_r[0] != 8'h00) begin
               cnt_nxt[0] = cnt_r[0] - 8'h01;
            end else if (cnt_r[1] != 8'h00) begin
               cnt_nxt[0] = CNT_MAX;
               cnt_nxt[1] = cnt_r[1] - 8'h01;
            end else begin
               cnt_nxt[0] = rld_r[0];
               cnt_nxt[1] = rld_r[1];
               uf_now     = 2'h3;
            end
         end
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (tick[i]) begin
               if (cnt_r[i] == 8'h00) begin
                  cnt_nxt[i] = rld_r[i];
                  uf_now[i]  = 1'b1;
               end else begin
                  cnt_nxt[i] = cnt_r[i] - 8'h01;
               end
            end
         end
      end
      // A preset overrides; with an underflow the same value loads once
      for (int i = 0; i < 2; i++) begin
         if (preset[i]) begin
            cnt_nxt[i] = rld_r[i];
         end
      end
      flag_nxt  = (flag_r & ~flag_clr) | uf_now;
      irq_nxt   = flag_nxt & irqen_r;
      pulse_nxt = pulse_r ^ (ctrl_r[CB_PULSE_OUT_CHANNEL_SELECT] ? uf_now[1] : uf_now[0]);
      sio_nxt   = sio_r ^ uf_now[1];
   end

   always_ff @(posedge CLK_IN) begin
      if (RST_IN) begin
         cnt_r[0] <= CNT_RST;
         cnt_r[1] <= CNT_RST;
         uf_r     <= 2'h0;
         flag_r   <= 2'h0;
         irq_r    <= 2'h0;
         pulse_r  <= 1'b0;
         sio_r    <= 1'b0;
      end else begin
         cnt_r[0] <= cnt_nxt[0];
         cnt_r[1] <= cnt_nxt[1];
         uf_r     <= uf_now;
         flag_r   <= flag_nxt;
         irq_r    <= irq_nxt;
         pulse_r  <= pulse_nxt;
         sio_r    <= sio_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign PRDATA_OUT       = prdata_r;
   assign PREADY_OUT       = pready_r;
   assign PSLVERR_OUT      = pslverr_r;
   assign PULSE_OUTPUT_OUT = pulse_r;
   assign SIO_CLK_OUT      = sio_r;
   assign UNDERFLOW_OUT    = uf_r;
   assign IRQ_OUT          = irq_r;

endmodule // dr_counter_top

// ==== rtl/dr_evt_cond.sv ====
// Event input conditioner: pin synchroniser, noise rejector and edge select
module dr_evt_cond
   import dr_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic rst_in,
   dr_evt_if.cond    ev
);

   logic [NSYNC-1:0] sync_r,  sync_nxt;
   logic             lvl_r,   lvl_nxt;
   logic             filt_r,  filt_nxt;
   dr_filt_e         st_r,    st_nxt;
   logic [1:0]       nref_r,  nref_nxt;
   logic             tick_r,  tick_nxt;

   always_comb begin
      sync_nxt = {sync_r[NSYNC-2:0], ev.pin};
      // A level counts only once the second and third stages agree
      lvl_nxt  = (sync_r[1] == sync_r[2]) ? sync_r[2] : lvl_r;
      filt_nxt = filt_r;
      st_nxt   = st_r;
      nref_nxt = nref_r;
      if (!ev.filt_en) begin
         filt_nxt = lvl_r;
         st_nxt   = FS_STABLE;
         nref_nxt = 2'h0;
      end else begin
         case (st_r)
            FS_STABLE: begin
               if (lvl_r != filt_r) begin
                  st_nxt   = FS_PENDING;
                  nref_nxt = 2'h0;
               end
            end
            FS_PENDING: begin
               // Level back before the second reference edge: a glitch, dropped
               if (lvl_r == filt_r) begin
                  st_nxt = FS_STABLE;
               end else if (ev.ref_fall) begin
                  if (nref_r == FILT_EDGES - 2'h1) begin
                     filt_nxt = lvl_r;
                     st_nxt   = FS_STABLE;
                  end else begin
                     nref_nxt = nref_r + 2'h1;
                  end
               end
            end
            default: begin
               st_nxt = FS_STABLE;
            end
         endcase
      end
      // One pulse per accepted edge of the chosen direction
      tick_nxt = (filt_nxt != filt_r) && (filt_nxt == ev.polarity);
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         sync_r <= '0;
         lvl_r  <= 1'b0;
         filt_r <= 1'b0;
         st_r   <= FS_STABLE;
         nref_r <= 2'h0;
         tick_r <= 1'b0;
      end else begin
         sync_r <= sync_nxt;
         lvl_r  <= lvl_nxt;
         filt_r <= filt_nxt;
         st_r   <= st_nxt;
         nref_r <= nref_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign ev.evt_tick = tick_r;

endmodule // dr_evt_cond

// ==== verif/dr_counter_checker.sv ====
// Concurrent checks on the dual reload down counter ports
module dr_counter_checker
   import dr_pkg::*;
(
   input wire logic                      CLK_IN,
   input wire logic                      RST_IN,
   input wire logic                      PSEL_IN,
   input wire logic                      PENABLE_IN,
   input wire logic                      PWRITE_IN,
   input wire logic [dr_pkg::APB_AW-1:0] PADDR_IN,
   input wire logic                      PREADY_OUT,
   input wire logic                      PSLVERR_OUT,
   input wire logic                      PULSE_OUTPUT_OUT,
   input wire logic                      SIO_CLK_OUT,
   input wire logic [1:0]                UNDERFLOW_OUT,
   input wire logic [1:0]                IRQ_OUT
);
   default clocking cb @(posedge CLK_IN); endclocking
   default disable iff (RST_IN);

   ////////////////////////////////////////////////////////////////////////////
   property p_rdy_second;
      PSEL_IN && $rose(PENABLE_IN) |=> PREADY_OUT;
   endproperty
   a_rdy_second: assert property (p_rdy_second) else $error("late ready");
   property p_rdy_single;
      PREADY_OUT |=> !PREADY_OUT;
   endproperty
   a_rdy_single: assert property (p_rdy_single) else $error("long ready");
   property p_err_map;
      PREADY_OUT |-> PSLVERR_OUT == (PADDR_IN[1:0] != 2'h0 || PADDR_IN > OFS_IRQEN);
   endproperty
   a_err_map: assert property (p_err_map) else $error("bad error flag");
   property p_uf_single;
      UNDERFLOW_OUT[0] |=> !UNDERFLOW_OUT[0];
   endproperty
   a_uf_single: assert property (p_uf_single) else $error("long underflow");
   // Window of three cycles tolerates either pipeline order of toggle and pulse
   property p_sio_follow;
      UNDERFLOW_OUT[1] |-> ##1 SIO_CLK_OUT != $past(SIO_CLK_OUT, 3);
   endproperty
   a_sio_follow: assert property (p_sio_follow) else $error("no serial toggle");
   property p_sio_cause;
      $changed(SIO_CLK_OUT) |-> ##1 (UNDERFLOW_OUT[1] || $past(UNDERFLOW_OUT[1]) || $past(UNDERFLOW_OUT[1], 2));
   endproperty
   a_sio_cause: assert property (p_sio_cause) else $error("stray serial toggle");
   property p_pulse_cause;
      $changed(PULSE_OUTPUT_OUT) |-> ##1 (|UNDERFLOW_OUT || $past(|UNDERFLOW_OUT) || $past(|UNDERFLOW_OUT, 2));
   endproperty
   a_pulse_cause: assert property (p_pulse_cause) else $error("stray pulse toggle");
   property p_irq_clear;
      $fell(IRQ_OUT[0]) |-> $past(PREADY_OUT && PWRITE_IN) || $past(PREADY_OUT && PWRITE_IN, 2);
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("irq dropped alone");

   c_uf1: cover property (UNDERFLOW_OUT[1]);
   c_err: cover property (PREADY_OUT && PSLVERR_OUT);
   c_irq: cover property ($fell(IRQ_OUT[0]));
endmodule // dr_counter_checker

bind dr_counter_top dr_counter_checker dr_counter_checker_inst (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
   .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
   .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .PULSE_OUTPUT_OUT(PULSE_OUTPUT_OUT),
   .SIO_CLK_OUT(SIO_CLK_OUT), .UNDERFLOW_OUT(UNDERFLOW_OUT), .IRQ_OUT(IRQ_OUT));

// ==== verif/dr_evt_src.sv ====
// Behavioural external event source driving the event input pin
module dr_evt_src (
   output logic pin_out
);
   timeunit 1ns;
   timeprecision 1ns;

   initial pin_out = 1'b0;

   // Toggle n times; the small lead keeps changes off the bench clock edge
   task automatic edges(input int n, input int w);
      #7;
      repeat (n) begin
         pin_out = ~pin_out;
         #(w); // Counted levels are held 0.98 ms or more when filtering
      end
   endtask
endmodule // dr_evt_src

// ==== verif/tb.sv ====
// Self-checking bench for the dual reload down counter
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
   $display("BAD %0t got %0h exp %0h", $time, (g), (e)); end end
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   import dr_pkg::*;
   logic        CLK_IN = 1'b0, RST_IN = 1'b1, PSEL_IN = 1'b0, PENABLE_IN = 1'b0, PWRITE_IN = 1'b0;
   logic        LOW_FREQ_OSC_IN = 1'b0, HIGH_FREQ_OSC_IN = 1'b0, e, pe, w;
   logic [7:0]  PADDR_IN = 8'h00;
   logic [31:0] PWDATA_IN = 32'h0, PRDATA_OUT, q, v;
   logic        PREADY_OUT, PSLVERR_OUT, PULSE_OUTPUT_OUT, SIO_CLK_OUT, EVENT_INPUT_PIN_IN;
   logic [1:0]  UNDERFLOW_OUT, IRQ_OUT;
   int          num_errors = 0, samples_checked = 0, seed = 32'h78513BF0;
   int          c, r, s, t, lf = 0, hf = 0;

   dr_counter_top dr_counter_top_inst (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .PSEL_IN(PSEL_IN),
      .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
      .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
      .LOW_FREQ_OSC_IN(LOW_FREQ_OSC_IN), .HIGH_FREQ_OSC_IN(HIGH_FREQ_OSC_IN),
      .EVENT_INPUT_PIN_IN(EVENT_INPUT_PIN_IN), .PULSE_OUTPUT_OUT(PULSE_OUTPUT_OUT),
      .SIO_CLK_OUT(SIO_CLK_OUT), .UNDERFLOW_OUT(UNDERFLOW_OUT), .IRQ_OUT(IRQ_OUT));
   dr_evt_src dr_evt_src_inst (.pin_out(EVENT_INPUT_PIN_IN));

   always #50 CLK_IN = ~CLK_IN;
   // Low oscillator period 306 cycles, high oscillator period 10 cycles
   always @(posedge CLK_IN) begin
      lf <= (lf == 152) ? 0 : lf + 1;
      hf <= (hf == 4) ? 0 : hf + 1;
      if (lf == 152) LOW_FREQ_OSC_IN <= ~LOW_FREQ_OSC_IN;
      if (hf == 4) HIGH_FREQ_OSC_IN <= ~HIGH_FREQ_OSC_IN;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("errors %0d checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Cycles between underflows: reload plus one ticks of the prescaled source
   function automatic int exp_gap(input int rl, input int code, input int per);
      return (rl + 1) * (code == 0 ? 1 : code == 1 ? 4 : code == 2 ? 32 : 256) * per;
   endfunction

   task automatic stall();
      num_errors++;
      $display("BAD %0t timeout", $time);
      complete_run();
   endtask

   // Idle edges around each transfer keep every signal to one assignment per step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge CLK_IN);
      PSEL_IN <= 1'b1;
      PWRITE_IN <= w;
      PADDR_IN <= a;
      PWDATA_IN <= d;
      @(posedge CLK_IN);
      PENABLE_IN <= 1'b1;
      do begin
         @(posedge CLK_IN);
         n++;
      end while (PREADY_OUT !== 1'b1 && n < 20);
      q = PRDATA_OUT;
      e = PSLVERR_OUT;
      PSEL_IN <= 1'b0;
      PENABLE_IN <= 1'b0;
      if (n >= 20) stall();
      repeat (2) @(posedge CLK_IN);
   endtask

   // Cycles between two successive underflows of channel i
   task automatic gap(input int i);
      int   k;
      logic po;
      k = 0;
      po = 1'b0;
      repeat (2) begin
         c = 0;
         do begin
            po = PULSE_OUTPUT_OUT;
            @(posedge CLK_IN);
            k++;
            c++;
         end while (UNDERFLOW_OUT[i] !== 1'b1 && k < 40000);
      end
      // Pulse output must have toggled with the underflow just seen
      w = PULSE_OUTPUT_OUT ^ po;
      if (k >= 40000) stall();
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge CLK_IN);
      RST_IN <= 1'b0;
      apb(1'b1, 8'h02, 32'h7F);
      `CHK(e, 1'b1)
      apb(1'b0, 8'h24, 0);
      `CHK({e, q}, 33'h100000000)
      apb(1'b0, OFS_CTRL, 0);
      `CHK(q, 32'h0)
      r = $random(seed) & 7;
      apb(1'b1, OFS_RLD0, r);
      apb(1'b0, OFS_RLD0, 0);
      `CHK(q, 32'(r))
      apb(1'b1, OFS_PRESET, 1);
      apb(1'b1, OFS_CTRL, 32'h20);
      gap(0);
      `CHK(c, exp_gap(r, 0, 306))
      `CHK(w, 1'b1)
      apb(1'b1, OFS_RLD0, 1);
      apb(1'b1, OFS_RLD1, 1);
      apb(1'b1, OFS_CLKSEL, 32'h04);
      apb(1'b1, OFS_PRESET, 3);
      apb(1'b1, OFS_CTRL, 32'h21);
      gap(0);
      `CHK(c, exp_gap(257, 0, 10))
      `CHK(w, 1'b1)
      apb(1'b1, OFS_CTRL, 32'h10);
      pe = PULSE_OUTPUT_OUT ^ SIO_CLK_OUT;
      for (int k = 0; k < 4; k++) begin
         r = $random(seed) & 3;
         apb(1'b1, OFS_CTRL, 32'h10);
         apb(1'b1, OFS_CLKSEL, 32'h40 | (k << 4));
         apb(1'b1, OFS_RLD1, r);
         apb(1'b1, OFS_PRESET, 2);
         apb(1'b1, OFS_CTRL, 32'h50);
         gap(1);
         `CHK(c, exp_gap(r, k, 10))
         `CHK(w, 1'b1)
         repeat (3) @(posedge CLK_IN);
         `CHK(PULSE_OUTPUT_OUT ^ SIO_CLK_OUT, pe)
      end
      apb(1'b1, OFS_CTRL, 32'h10);
      apb(1'b0, OFS_CNT1, 0);
      v = q;
      repeat (3000) @(posedge CLK_IN);
      apb(1'b0, OFS_CNT1, 0);
      `CHK(q, v)
      // Low read freezes channel 1; a preset meanwhile must not show until released
      apb(1'b0, OFS_CNT0, 0);
      apb(1'b1, OFS_RLD1, 32'hA5);
      apb(1'b1, OFS_PRESET, 2);
      apb(1'b0, OFS_CNT1, 0);
      `CHK(q, v)
      apb(1'b0, OFS_CNT1, 0);
      `CHK(q, 32'hA5)
      apb(1'b0, OFS_FLAG, 0);
      `CHK(q, 32'h3)
      `CHK(IRQ_OUT, 2'h0)
      apb(1'b1, OFS_IRQEN, 3);
      `CHK(IRQ_OUT, 2'h3)
      apb(1'b1, OFS_FLAG, 1);
      `CHK(IRQ_OUT, 2'h2)
      // Prescaler left fast so any leak into event counting shows
      apb(1'b1, OFS_CLKSEL, 32'h04);
      apb(1'b1, OFS_RLD0, 32'hFF);
      for (int p = 0; p < 2; p++) begin
         apb(1'b1, OFS_CTRL, 32'h22 | (p << 2));
         apb(1'b1, OFS_PRESET, 1);
         s = EVENT_INPUT_PIN_IN;
         t = 1 + ($random(seed) & 15);
         dr_evt_src_inst.edges(t, 800);
         apb(1'b0, OFS_CNT0, 0);
         `CHK(q, 32'(255 - ((p != s) ? (t + 1) / 2 : t / 2)))
      end
      if (EVENT_INPUT_PIN_IN) dr_evt_src_inst.edges(1, 1000);
      apb(1'b1, OFS_CTRL, 32'h2A);
      apb(1'b1, OFS_PRESET, 1);
      dr_evt_src_inst.edges(2, 300000);
      dr_evt_src_inst.edges(2, 1200000);
      apb(1'b0, OFS_CNT0, 0);
      `CHK(q, 32'hFE)
      complete_run();
   end
endmodule // tb
